// file: hdl/lf_cmd_pkg.sv
// Purpose: constants shared by the lf driver command interpreter
// Assumes: 8-bit spi words, lsb first, system clock 125 MHz
// Notes: command codes are first-word values as received
package lf_cmd_pkg;
   localparam int WORD_W = 8;
   localparam int SYNC_W = 3;
   localparam int LBITS = 96;
   localparam int PTR_W = 7;
   localparam logic [7:0] CMD_STATUS = 8'h00;
   localparam logic [7:0] CMD_FAULT_RST = 8'h11;
   localparam logic [7:0] CMD_STOP = 8'h21;
   localparam logic [7:0] CMD_PDOWN = 8'h41;
   localparam logic [7:0] CMD_WR_CFG1 = 8'h04;
   localparam logic [7:0] CMD_RD_CFG1 = 8'h06;
   localparam logic [7:0] CMD_WR_CFG2 = 8'h08;
   localparam logic [7:0] CMD_RD_CFG2 = 8'h0A;
   localparam logic [7:0] CMD_RD_STAT = 8'h0E;
   localparam logic [7:0] CMD_RD_FREE = 8'h02;
   localparam int LF_DATA_BIT = 7;
   localparam int READY_BIT = 7;
   localparam int RTS_BIT = 1;
   localparam int ILLEGAL_BIT = 5;
   localparam logic [4:0] CFG1_RESET = 5'h00;
   localparam logic [2:0] CFG2_RESET = 3'h0;
   localparam logic [5:0] FAULT_RESET = 6'h00;
   localparam logic [6:0] PTR_BOTTOM = 7'h00;
   localparam logic [6:0] PTR_TOP = 7'd96;
   localparam logic [2:0] BITCNT_LAST = 3'h7;
   // half-bit times in us, one per baud selector value
   localparam int HALF_US_0 = 512;
   localparam int HALF_US_1 = 256;
   localparam int HALF_US_2 = 160;
   localparam int HALF_US_3 = 128;
   localparam int CLK_MHZ = 125;
   localparam logic [16:0] HALF_CYC_0 = 17'(HALF_US_0 * CLK_MHZ);
   localparam logic [16:0] HALF_CYC_1 = 17'(HALF_US_1 * CLK_MHZ);
   localparam logic [16:0] HALF_CYC_2 = 17'(HALF_US_2 * CLK_MHZ);
   localparam logic [16:0] HALF_CYC_3 = 17'(HALF_US_3 * CLK_MHZ);
endpackage : lf_cmd_pkg

// file: hdl/spi_word_shifter.sv
// Purpose: spi slave that shifts 8-bit words lsb first
// Assumes: mode 0, sampled on rising sclk, data out changes on falling sclk
// Notes: pins pass three flops; a word cut short by chip select is dropped
module spi_word_shifter
   import lf_cmd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   input wire logic [7:0] tx_word_i,
   output logic miso_o,
   output logic [7:0] rx_word_o,
   output logic rx_valid_o,
   output logic cs_active_o
);
   typedef struct packed {
      logic [2:0] sclk;
      logic [2:0] csn;
      logic [2:0] mosi;
      logic [2:0] cnt;
      logic [7:0] sh;
      logic [7:0] tx;
      logic miso;
      logic [7:0] rx;
      logic vld;
   } shift_s;
   shift_s s_q, s_d;
   logic cs_on, rise, fall;

   // chip select needs agreement of second and third stage; a difference between them marks an sclk edge
   always_comb begin
      s_d = s_q;
      s_d.sclk = {s_q.sclk[1:0], sclk_i};
      s_d.csn = {s_q.csn[1:0], cs_n_i};
      s_d.mosi = {s_q.mosi[1:0], mosi_i};
      s_d.vld = 1'b0;
      cs_on = ~s_q.csn[1] & ~s_q.csn[2];
      rise = s_q.sclk[1] & ~s_q.sclk[2];
      fall = ~s_q.sclk[1] & s_q.sclk[2];
      if (!cs_on) begin
         s_d.cnt = 3'h0;
         s_d.tx = tx_word_i;
         s_d.miso = tx_word_i[0];
      end else begin
         if (rise) begin
            s_d.sh = {s_q.mosi[2], s_q.sh[7:1]};
            s_d.cnt = s_q.cnt + 3'h1;
            s_d.tx = {1'b0, s_q.tx[7:1]};
            if (s_q.cnt == BITCNT_LAST) begin
               s_d.rx = {s_q.mosi[2], s_q.sh[7:1]};
               s_d.vld = 1'b1;
            end
         end
         // answer loaded on the fall after a word, once the decoder has replied
         if (fall) begin
            if (s_q.cnt == 3'h0) begin
               s_d.tx = tx_word_i;
               s_d.miso = tx_word_i[0];
            end else begin
               s_d.miso = s_q.tx[0];
            end
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.sclk <= 3'h0;
         s_q.csn <= 3'h7;
         s_q.mosi <= 3'h0;
      end else begin
         s_q <= s_d;
      end
   end

   assign miso_o = s_q.miso;
   assign rx_word_o = s_q.rx;
   assign rx_valid_o = s_q.vld;
   assign cs_active_o = ~s_q.csn[2];
endmodule : spi_word_shifter

// file: hdl/lf_driver_spi_command_buffer.sv
// Purpose: spi command interpreter and lf half-bit buffer for an lf antenna driver
// Assumes: faults arrive as level inputs from the diagnosis stage
// Notes: buffer is 96 entries of two half bits each
module lf_driver_spi_command_buffer
   import lf_cmd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   input wire logic [4:0] fault_detect_i,
   output logic miso_o,
   output logic [3:0] coil_current_selector_o,
   output logic modulation_type_select_o,
   output logic [1:0] lf_baud_selector_o,
   output logic clock_output_pin_prescale_o,
   output logic stages_enable_o,
   output logic carrier_on_o,
   output logic mod_active_o,
   output logic power_down_o
);
   typedef enum logic [2:0] {
      ST_CMD = 3'b000,
      ST_ARG = 3'b001,
      ST_LF = 3'b011,
      ST_PDN = 3'b010
   } cmd_state_e;

   typedef struct packed {
      cmd_state_e st;
      logic [7:0] first;
      logic [6:0] remain;
      logic [4:0] cfg1;
      logic [2:0] cfg2;
      logic [5:0] fault;
      logic [6:0] ptr;
      logic [95:0] lower;
      logic [95:0] upper;
      logic running;
      logic phase;
      logic [16:0] tmr;
      logic [7:0] tx;
      logic carrier;
      logic stop_req;
      logic pdn_arm;
   } ctl_s;
   ctl_s c_q, c_d;

   logic [7:0] rx_word;
   logic rx_valid, cs_active, miso;
   logic [5:0] free_cnt;
   logic stage_fault, full, legal;
   logic [16:0] half_cyc;
   logic [2:0] nbits;

   spi_word_shifter u_shift (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sclk_i(sclk_i),
      .cs_n_i(cs_n_i),
      .mosi_i(mosi_i),
      .tx_word_i(c_q.tx),
      .miso_o(miso),
      .rx_word_o(rx_word),
      .rx_valid_o(rx_valid),
      .cs_active_o(cs_active)
   );

   // status and buffer levels
   always_comb begin
      stage_fault = |c_q.fault[4:0];
      full = (c_q.ptr == PTR_TOP);
      free_cnt = 6'(PTR_TOP - c_q.ptr);
      unique case (c_q.cfg2[2:1])
         2'b00: half_cyc = HALF_CYC_0;
         2'b01: half_cyc = HALF_CYC_1;
         2'b10: half_cyc = HALF_CYC_2;
         default: half_cyc = HALF_CYC_3;
      endcase
      legal = (rx_word == CMD_STATUS) || (rx_word == CMD_FAULT_RST) || (rx_word == CMD_STOP) ||
              (rx_word == CMD_PDOWN) || (rx_word == CMD_WR_CFG1) || (rx_word == CMD_RD_CFG1) ||
              (rx_word == CMD_WR_CFG2) || (rx_word == CMD_RD_CFG2) || (rx_word == CMD_RD_STAT) ||
              (rx_word == CMD_RD_FREE) || rx_word[LF_DATA_BIT];
   end

   // command decode, buffer and modulator
   always_comb begin
      c_d = c_q;
      nbits = 3'h0;
      // fault flags set over clear
      c_d.fault[4:0] = c_q.fault[4:0] | fault_detect_i;
      // modulator: bottom entry, two half bits, lower first
      if (c_q.running) begin
         if (c_q.tmr == 17'h0_0001) begin
            c_d.tmr = half_cyc;
            if (!c_q.phase) begin
               c_d.phase = 1'b1;
               c_d.carrier = c_q.upper[0];
            end else begin
               c_d.lower = {1'b0, c_q.lower[95:1]};
               c_d.upper = {1'b0, c_q.upper[95:1]};
               c_d.ptr = c_q.ptr - 7'h1;
               c_d.phase = 1'b0;
               if (c_q.ptr == 7'h1) begin
                  c_d.running = 1'b0;
                  c_d.carrier = 1'b0;
               end else begin
                  c_d.carrier = c_q.lower[1];
               end
            end
         end else begin
            c_d.tmr = c_q.tmr - 17'h0_0001;
         end
      end
      // word handling
      if (rx_valid) begin
         c_d.tx = {1'b1, 5'h00, ~(full | stage_fault), 1'b0};
         unique case (c_q.st)
            ST_CMD: begin
               c_d.first = rx_word;
               if (rx_word[LF_DATA_BIT]) begin
                  c_d.remain = rx_word[6:0];
                  c_d.st = (rx_word[6:0] == 7'h00) ? ST_CMD : ST_LF;
               end else if (!legal) begin
                  c_d.fault[ILLEGAL_BIT] = 1'b1;
               end else if (rx_word == CMD_FAULT_RST) begin
                  c_d.fault = fault_detect_i[4:0] == 5'h00 ? FAULT_RESET : {1'b0, fault_detect_i};
               end else if (rx_word == CMD_STOP) begin
                  c_d.stop_req = 1'b1;
               end else if (rx_word == CMD_PDOWN) begin
                  c_d.st = ST_PDN;
               end else if (rx_word != CMD_STATUS) begin
                  c_d.st = ST_ARG;
                  unique case (rx_word)
                     CMD_WR_CFG1, CMD_WR_CFG2: c_d.tx = rx_word;
                     CMD_RD_CFG1: c_d.tx = {2'b00, c_q.cfg1[4:1], 1'b0, c_q.cfg1[0]};
                     CMD_RD_CFG2: c_d.tx = {5'h00, c_q.cfg2};
                     CMD_RD_STAT: c_d.tx = {2'h0, c_q.fault};
                     default: c_d.tx = {2'h0, free_cnt};
                  endcase
               end
            end
            ST_ARG: begin
               if (c_q.first == CMD_WR_CFG1) begin
                  c_d.cfg1 = {rx_word[5:2], rx_word[0]};
               end else if (c_q.first == CMD_WR_CFG2) begin
                  c_d.cfg2 = rx_word[2:0];
               end
               c_d.st = ST_CMD;
            end
            ST_LF: begin
               // up to four logical bits, lsb first
               nbits = (c_q.remain > 7'd4) ? 3'd4 : c_q.remain[2:0];
               for (int i = 0; i < 4; i++) begin
                  if (3'(i) < nbits && c_d.ptr < PTR_TOP && !stage_fault) begin
                     c_d.lower[c_d.ptr] = rx_word[2 * i];
                     c_d.upper[c_d.ptr] = rx_word[2 * i + 1];
                     c_d.ptr = c_d.ptr + 7'h1;
                  end
               end
               c_d.remain = c_q.remain - 7'(nbits);
               if (c_q.remain <= 7'd4) begin
                  c_d.st = ST_CMD;
                  if (!c_d.running && c_d.ptr != PTR_BOTTOM && !stage_fault) begin
                     c_d.running = 1'b1;
                     c_d.phase = 1'b0;
                     c_d.tmr = half_cyc;
                     c_d.carrier = c_d.lower[0];
                  end
               end
            end
            default: ;
         endcase
      end
      // a cut word or dropped select ends the command
      if (!cs_active) begin
         if (c_q.st == ST_PDN) begin
            c_d.pdn_arm = 1'b1;
         end
         if (c_q.st != ST_PDN || c_q.pdn_arm) begin
            c_d.st = ST_CMD;
         end
         c_d.tx = {1'b1, 5'h00, ~(full | stage_fault), 1'b0};
      end else begin
         c_d.pdn_arm = 1'b0;
      end
      // stop or fault flushes and idles
      if (c_q.stop_req || stage_fault) begin
         c_d.running = 1'b0;
         c_d.ptr = PTR_BOTTOM;
         c_d.lower = '0;
         c_d.upper = '0;
         c_d.carrier = 1'b0;
         c_d.stop_req = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         c_q <= '0;
         c_q.st <= ST_CMD;
         c_q.cfg1 <= CFG1_RESET;
         c_q.cfg2 <= CFG2_RESET;
         c_q.fault <= FAULT_RESET;
         c_q.ptr <= PTR_BOTTOM;
         c_q.tx <= 8'h80;
      end else begin
         c_q <= c_d;
      end
   end

   // registered output copies
   logic miso_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         miso_q <= 1'b0;
      end else begin
         miso_q <= miso;
      end
   end

   logic stages_on_q;
   assign miso_o = miso_q;
   assign coil_current_selector_o = c_q.cfg1[4:1];
   assign modulation_type_select_o = c_q.cfg1[0];
   assign lf_baud_selector_o = c_q.cfg2[2:1];
   assign clock_output_pin_prescale_o = c_q.cfg2[0];
   assign stages_enable_o = stages_on_q;
   assign carrier_on_o = c_q.carrier;
   assign mod_active_o = c_q.running;
   assign power_down_o = c_q.pdn_arm;

   // stage enable flop, low while a power fault is latched
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         stages_on_q <= 1'b1;
      end else begin
         stages_on_q <= ~(|c_d.fault[4:0]);
      end
   end

   // fault blocks stages within two cycles
   property p_fault_off;
      @(posedge clk_i) disable iff (rst_i) (|fault_detect_i) |-> ##[1:2] !stages_enable_o;
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("stages on after fault");

   property p_ptr_top;
      @(posedge clk_i) disable iff (rst_i) c_q.ptr <= PTR_TOP;
   endproperty
   a_ptr_top: assert property (p_ptr_top) else $error("pointer over top");

   property p_illegal;
      @(posedge clk_i) disable iff (rst_i) (rx_valid && c_q.st == ST_CMD && !legal) |=> c_q.fault[ILLEGAL_BIT];
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal command not flagged");

   property p_stop;
      @(posedge clk_i) disable iff (rst_i) c_q.stop_req |=> (c_q.ptr == PTR_BOTTOM && !c_q.running);
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not flush");

   property p_run_data;
      @(posedge clk_i) disable iff (rst_i) c_q.running |-> c_q.ptr != PTR_BOTTOM;
   endproperty
   a_run_data: assert property (p_run_data) else $error("modulator running empty");

   property p_ask;
      @(posedge clk_i) disable iff (rst_i) !c_q.running |-> !carrier_on_o;
   endproperty
   a_ask: assert property (p_ask) else $error("carrier on while idle");

   property p_fault_hold;
      @(posedge clk_i) disable iff (rst_i) (c_q.fault[0] && !(rx_valid && c_q.st == ST_CMD)) |=> c_q.fault[0];
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault flag lost");

   property p_ptr_fault;
      @(posedge clk_i) disable iff (rst_i) stage_fault |=> c_q.ptr == PTR_BOTTOM;
   endproperty
   a_ptr_fault: assert property (p_ptr_fault) else $error("pointer not at bottom in fault");
endmodule : lf_driver_spi_command_buffer

// file: test/spi_master_model.sv
// Purpose: spi master standing in for the controller
// Assumes: mode 0, each sclk phase lasts six system clocks
// Notes: mosi is inverted when chip select is released
module spi_master_model
(
   input wire logic clk_i,
   input wire logic miso_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle levels
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // one sclk phase, stepping just past the edge
   task automatic phase();
      repeat (6) @(posedge clk_i);
      #1;
   endtask : phase
   // select or release the device
   task automatic sel(input logic on);
      phase();
      cs_n_o = !on;
      if (!on) mosi_o = !mosi_o;
      phase();
   endtask : sel
   // shift n bits of one word, lsb first
   task automatic word(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < n; i++) begin
         mosi_o = tx[i];
         phase();
         rx[i] = miso_i;
         sclk_o = 1'b1;
         phase();
         sclk_o = 1'b0;
      end
   endtask : word
endmodule : spi_master_model

// file: test/tb.sv
// Purpose: self-checking bench for the lf command interpreter
// Assumes: fastest baud for modulation checks, ask mode
// Notes: free count of 96 reads back as 32 in six bits
module tb
   import lf_cmd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0;
   logic rst_i;
   logic sclk, cs_n, mosi, miso, ask_psk, ps, stages, carrier, mod_act, pdown;
   logic [4:0] fault_detect;
   logic [3:0] coil;
   logic [1:0] baud;
   logic [7:0] a0, a1;
   logic [4:0] c1;
   logic [2:0] c2;
   logic [4:0] fv;
   int n_mismatch = 0;
   int checked = 0;
   // 125 MHz clock
   always #4 clk_i = !clk_i;
   lf_driver_spi_command_buffer lf_driver_spi_command_buffer_i (
      .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
      .fault_detect_i(fault_detect), .miso_o(miso), .coil_current_selector_o(coil),
      .modulation_type_select_o(ask_psk), .lf_baud_selector_o(baud),
      .clock_output_pin_prescale_o(ps), .stages_enable_o(stages), .carrier_on_o(carrier),
      .mod_active_o(mod_act), .power_down_o(pdown));
   spi_master_model spi_master_model_i (
      .clk_i(clk_i), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
   // compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // first-word answer
   function automatic logic [7:0] ans(input logic rts);
      return {1'b1, 5'h00, rts, 1'b0};
   endfunction : ans
   // one- or two-word command in one frame
   task automatic cmd(input logic [7:0] w0, input logic [7:0] w1, input int n);
      spi_master_model_i.sel(1'b1);
      spi_master_model_i.word(w0, 8, a0);
      if (n > 1) spi_master_model_i.word(w1, 8, a1);
      spi_master_model_i.sel(1'b0);
   endtask : cmd
   // lf data command, first data word given, rest random
   task automatic lf(input logic [6:0] nb, input logic [7:0] d0);
      logic [7:0] d;
      spi_master_model_i.sel(1'b1);
      spi_master_model_i.word({1'b1, nb}, 8, a0);
      d = d0;
      for (int i = 0; i < (nb + 3) / 4; i++) begin
         spi_master_model_i.word(d, 8, a1);
         d = 8'($urandom);
      end
      spi_master_model_i.sel(1'b0);
   endtask : lf
   // verdict
   task automatic end_sim();
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim
   // watchdog
   initial begin
      #(60_000 * 8);
      n_mismatch++;
      end_sim();
   end
   // main sequence
   initial begin
      rst_i = 1'b1;
      fault_detect = 5'h00;
      void'($urandom(58646));
      repeat (8) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      check({coil, ask_psk, baud, ps}, 8'h00);
      check({5'h00, stages, carrier, mod_act | pdown}, 8'h04);
      $display("reset test done");
      c1 = 5'($urandom);
      c2 = 3'($urandom);
      cmd(CMD_WR_CFG1, {2'b00, c1[4:1], 1'b0, c1[0]}, 2);
      check(a0, ans(1'b1));
      check(a1, CMD_WR_CFG1);
      check({3'h0, coil, ask_psk}, {3'h0, c1});
      cmd(CMD_RD_CFG1, 8'h00, 2);
      check(a1, {2'b00, c1[4:1], 1'b0, c1[0]});
      cmd(CMD_WR_CFG2, {5'h00, c2}, 2);
      check(a1, CMD_WR_CFG2);
      check({5'h00, baud, ps}, {5'h00, c2});
      cmd(CMD_RD_CFG2, 8'h00, 2);
      check(a1, {5'h00, c2});
      $display("config test done");
      cmd(8'h55, 8'h00, 1);
      cmd(CMD_RD_STAT, 8'h00, 2);
      check(a1, 8'h20);
      check({7'h00, stages}, 8'h01);
      cmd(CMD_FAULT_RST, 8'h00, 1);
      spi_master_model_i.sel(1'b1);
      spi_master_model_i.word(8'h55, 4, a0);
      spi_master_model_i.sel(1'b0);
      cmd(CMD_RD_STAT, 8'h00, 2);
      check(a1, 8'h00);
      $display("illegal test done");
      fv = 5'($urandom_range(31, 1));
      fault_detect = fv;
      repeat (20) @(posedge clk_i);
      #1;
      fault_detect = 5'h00;
      repeat (20) @(posedge clk_i);
      check({7'h00, stages}, 8'h00);
      lf(7'd4, 8'hFF);
      cmd(CMD_STATUS, 8'h00, 1);
      check(a0, ans(1'b0));
      cmd(CMD_RD_STAT, 8'h00, 2);
      check(a1, {3'h0, fv});
      cmd(CMD_RD_FREE, 8'h00, 2);
      check(a1, 8'd32);
      cmd(CMD_FAULT_RST, 8'h00, 1);
      repeat (8) @(posedge clk_i);
      check({7'h00, stages}, 8'h01);
      $display("fault test done");
      cmd(CMD_WR_CFG1, {2'b00, c1[4:1], 2'b00}, 2);
      cmd(CMD_WR_CFG2, 8'h06, 2);
      lf(7'd96, 8'hF6);
      repeat (8000) @(posedge clk_i);
      check({6'h00, mod_act, carrier}, 8'h02);
      lf(7'd4, 8'hFF);
      cmd(CMD_RD_FREE, 8'h00, 2);
      check(a1, 8'h00);
      cmd(CMD_STATUS, 8'h00, 1);
      check(a0, ans(1'b0));
      repeat (13000) @(posedge clk_i);
      check({6'h00, mod_act, carrier}, 8'h03);
      cmd(CMD_STOP, 8'h00, 1);
      repeat (8) @(posedge clk_i);
      check({6'h00, mod_act, carrier}, 8'h00);
      cmd(CMD_RD_FREE, 8'h00, 2);
      check(a1, 8'd32);
      $display("modulation test done");
      cmd(CMD_PDOWN, 8'h00, 1);
      repeat (8) @(posedge clk_i);
      check({7'h00, pdown}, 8'h01);
      $display("power-down test done");
      end_sim();
   end
endmodule : tb
